// >>> jesd_mode_pkg.sv
// Purpose: shared constants for the mode decoder and its alignment-sequence stream
// Assumes: only operating modes 0 and 1 are supported
// Notes: alignment-sequence octets follow the usual 14-octet link configuration layout
package jesd_mode_pkg;
  // ==========================================================
  // widths and sizes
  localparam int MODE_W = 5;
  localparam int KM1_W = 5;
  localparam int DID_W = 8;
  localparam int LANES_TOTAL = 16;
  localparam int LANES_PER_LINK_MAX = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int STREAM_W = 13;
  // ==========================================================
  // mode codes
  localparam logic [MODE_W-1:0] MODE_SINGLE12_8L = 5'h00;
  localparam logic [MODE_W-1:0] MODE_SINGLE12_16L = 5'h01;
  // ==========================================================
  // parameters common to modes 0 and 1
  localparam logic [4:0] MODE01_DECIM = 5'h01;
  localparam logic MODE01_INTERLEAVE = 1'b1;
  localparam logic [1:0] MODE01_LINKS = 2'h2;
  localparam logic [4:0] MODE01_RES = 5'h0C;
  localparam logic [1:0] MODE01_CTRL = 2'h0;
  localparam logic [4:0] MODE01_NPRIME = 5'h0C;
  localparam logic [3:0] MODE01_OCTETS = 4'h8;
  localparam logic [3:0] MODE01_SAMPLES = 4'h5;
  // per-mode lanes, converters and bits per clock
  localparam logic [3:0] MODE0_LANES = 4'h4;
  localparam logic [3:0] MODE0_CONV = 4'h4;
  localparam logic [2:0] MODE0_RATIO = 3'h4;
  localparam logic [3:0] MODE1_LANES = 4'h8;
  localparam logic [3:0] MODE1_CONV = 4'h8;
  localparam logic [2:0] MODE1_RATIO = 3'h2;
  localparam logic [2:0] RATIO_BYPASS = 3'h1;
  // multiframe limits for modes 0 and 1
  localparam logic [5:0] K_MIN = 6'h03;
  localparam logic [5:0] K_STEP = 6'h01;
  localparam logic [5:0] K_MAX = 6'h20;
  // ==========================================================
  // alignment-sequence fields
  localparam logic [2:0] JESDV_VAL = 3'h1;
  localparam logic [2:0] SUBCLASSV_VAL = 3'h1;
  localparam int SCR_BIT = 7;
  localparam int VER_LSB = 5;
  localparam logic [3:0] OCT_DID = 4'h0;
  localparam logic [3:0] OCT_ADJ_BID = 4'h1;
  localparam logic [3:0] OCT_LID = 4'h2;
  localparam logic [3:0] OCT_SCR_L = 4'h3;
  localparam logic [3:0] OCT_F = 4'h4;
  localparam logic [3:0] OCT_K = 4'h5;
  localparam logic [3:0] OCT_M = 4'h6;
  localparam logic [3:0] OCT_CS_N = 4'h7;
  localparam logic [3:0] OCT_SUB_NP = 4'h8;
  localparam logic [3:0] OCT_JV_S = 4'h9;
  localparam logic [3:0] OCT_HD_CF = 4'hA;
  localparam logic [3:0] OCT_RES1 = 4'hB;
  localparam logic [3:0] OCT_RES2 = 4'hC;
  localparam logic [3:0] OCT_CHKSUM = 4'hD;
endpackage

// >>> stream_fifo.sv
// Purpose: synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: full and empty come from pointers with one wrap bit
`timescale 1ns/1ps
module stream_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic full, empty, doWrite, doRead;

  assign full = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
  assign empty = (wrPtr_r == rdPtr_r);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[rdPtr_r[AW-1:0]];
  assign doWrite = inValid && !full;
  assign doRead = outReady && !empty;

  always_comb begin
    wrPtr_nxt = wrPtr_r + {{AW{1'b0}}, doWrite};
    rdPtr_nxt = rdPtr_r + {{AW{1'b0}}, doRead};
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
    end
  end

  // storage has no reset; only entries between the pointers are ever read
  always_ff @(posedge clk_sys) begin
    if (doWrite) begin
      mem[wrPtr_r[AW-1:0]] <= inData;
    end
  end
endmodule

// >>> ilas_octet_build.sv
// Purpose: selects one configuration octet of the alignment sequence
// Assumes: all count inputs already hold the minus-one encodings
// Notes: purely combinational; the caller registers the result
`timescale 1ns/1ps
module ilas_octet_build
  import jesd_mode_pkg::*;
(
  input wire logic [3:0] octetIdx,
  input wire logic [7:0] deviceId,
  input wire logic [4:0] laneId,
  input wire logic scrEnable,
  input wire logic [4:0] lanesM1,
  input wire logic [7:0] octetsM1,
  input wire logic [4:0] kM1,
  input wire logic [7:0] convM1,
  input wire logic [4:0] resM1,
  input wire logic [4:0] nPrimeM1,
  input wire logic [4:0] samplesM1,
  output logic [7:0] octet
);
  logic [7:0] checksum;

  // sum of field values, not of packed octets; fixed-zero fields add nothing
  always_comb begin
    checksum = deviceId + {3'h0, laneId} + {7'h0, scrEnable} + {3'h0, lanesM1} + octetsM1
      + {3'h0, kM1} + convM1 + {3'h0, resM1} + {5'h00, SUBCLASSV_VAL} + {3'h0, nPrimeM1}
      + {5'h00, JESDV_VAL} + {3'h0, samplesM1};
  end

  always_comb begin
    octet = 8'h00;
    unique case (octetIdx)
      OCT_DID: octet = deviceId;
      OCT_ADJ_BID: octet = 8'h00;
      OCT_LID: octet = {3'h0, laneId};
      OCT_SCR_L: octet = {scrEnable, 2'h0, lanesM1};
      OCT_F: octet = octetsM1;
      OCT_K: octet = {3'h0, kM1};
      OCT_M: octet = convM1;
      OCT_CS_N: octet = {3'h0, resM1};
      OCT_SUB_NP: octet = {SUBCLASSV_VAL, nPrimeM1};
      OCT_JV_S: octet = {JESDV_VAL, samplesM1};
      OCT_HD_CF: octet = 8'h00;
      OCT_RES1: octet = 8'h00;
      OCT_RES2: octet = 8'h00;
      OCT_CHKSUM: octet = checksum;
      default: octet = 8'h00;
    endcase
  end
endmodule

// >>> jesd_mode_param_decode.sv
// Purpose: decodes the operating-mode code into the link parameter set and streams alignment octets
// Assumes: software changes configuration inputs only while linkEnable is low
// Notes: one stream word per lane per octet, lane-major, through an 8-word FIFO
// Functional notes
// - one mode code alone yields every link parameter except multiframe length, device identifier and scrambler enable.
// - interleave flag is one for single-channel modes, zero for dual.
// - bits-per-clock ratio sets serializer PLL multiplier or selects bypass.
// - multiframe length comes from the software field, not the mode.
// - every link-format parameter is sent during the alignment sequence.
// - adjust count, direction, bank, control words, density, reserved fields send zero.
// - control-bits-per-sample field always sends zero.
// - standard revision and subclass version both send one.
// - device identifier sent equals the software-written value.
// - scrambler enable comes from software and is reported in alignment sequence.
// - checksum is sum of preceding fields modulo 256.
// - lane identifier is the lane position inside its link.
// - converter count governs packing only, not physical channel count.
// - bits-per-sample field is width after control and tail bits.
// - mode zero: 12-bit interleaved, two links of four lanes, ratio four.
// - mode one: 12-bit interleaved, two links of eight lanes, ratio two.
// - lowest lanes of each link drive; unused higher lanes power down.
`timescale 1ns/1ps
module jesd_mode_param_decode
  import jesd_mode_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [MODE_W-1:0] linkModeCode,
  input wire logic [KM1_W-1:0] framesPerMultiframeMinusOne,
  input wire logic [DID_W-1:0] deviceId,
  input wire logic scramblerEnable,
  input wire logic linkEnable,
  input wire logic ilasReady,
  output logic modeValid,
  output logic kValid,
  output logic interleaveEnable,
  output logic [4:0] decimationFactor,
  output logic [1:0] linkCount,
  output logic [4:0] sampleResolution,
  output logic [1:0] controlBitsPerSample,
  output logic [4:0] bitsPerSample,
  output logic [3:0] lanesPerLink,
  output logic [3:0] convertersPerLink,
  output logic [3:0] octetsPerFrame,
  output logic [3:0] samplesPerFrame,
  output logic [2:0] bitsPerClock,
  output logic [2:0] pllMultiplier,
  output logic pllBypass,
  output logic [5:0] multiframeLength,
  output logic scramblerActive,
  output logic [LANES_TOTAL-1:0] laneEnable,
  output logic ilasBusy,
  output logic ilasValid,
  output logic [7:0] ilasData,
  output logic [3:0] ilasLane,
  output logic ilasLast
);
  typedef enum logic [1:0] {IDLE, EMIT, HOLD} state_type;

  // ==========================================================
  // mode decode
  logic modeValid_r, modeValid_nxt, kValid_r, kValid_nxt;
  logic interleave_r, interleave_nxt, pllBypass_r, pllBypass_nxt, scr_r, scr_nxt;
  logic [4:0] decim_r, decim_nxt, res_r, res_nxt, nPrime_r, nPrime_nxt;
  logic [1:0] links_r, links_nxt, ctrl_r, ctrl_nxt;
  logic [3:0] lanes_r, lanes_nxt, conv_r, conv_nxt, octets_r, octets_nxt, samples_r, samples_nxt;
  logic [2:0] ratio_r, ratio_nxt, pllMult_r, pllMult_nxt;
  logic [5:0] kLen_r, kLen_nxt;
  logic [KM1_W-1:0] km1_r, km1_nxt;
  logic [DID_W-1:0] did_r, did_nxt;
  logic [LANES_TOTAL-1:0] laneEn_r, laneEn_nxt;

  always_comb begin
    modeValid_nxt = 1'b1;
    interleave_nxt = MODE01_INTERLEAVE;
    decim_nxt = MODE01_DECIM;
    links_nxt = MODE01_LINKS;
    res_nxt = MODE01_RES;
    ctrl_nxt = MODE01_CTRL;
    nPrime_nxt = MODE01_NPRIME;
    octets_nxt = MODE01_OCTETS;
    samples_nxt = MODE01_SAMPLES;
    lanes_nxt = MODE0_LANES;
    conv_nxt = MODE0_CONV;
    ratio_nxt = MODE0_RATIO;
    unique case (linkModeCode)
      MODE_SINGLE12_8L: begin
        lanes_nxt = MODE0_LANES;
        conv_nxt = MODE0_CONV;
        ratio_nxt = MODE0_RATIO;
      end
      MODE_SINGLE12_16L: begin
        lanes_nxt = MODE1_LANES;
        conv_nxt = MODE1_CONV;
        ratio_nxt = MODE1_RATIO;
      end
      default: begin
        // unsupported code: every mode-derived parameter zero, lanes off, no stream
        modeValid_nxt = 1'b0;
        interleave_nxt = 1'b0;
        decim_nxt = 5'h00;
        links_nxt = 2'h0;
        res_nxt = 5'h00;
        nPrime_nxt = 5'h00;
        octets_nxt = 4'h0;
        samples_nxt = 4'h0;
        lanes_nxt = 4'h0;
        conv_nxt = 4'h0;
        ratio_nxt = 3'h0;
      end
    endcase
    pllBypass_nxt = (ratio_nxt == RATIO_BYPASS);
    pllMult_nxt = pllBypass_nxt ? 3'h0 : ratio_nxt;
    km1_nxt = framesPerMultiframeMinusOne;
    kLen_nxt = {1'b0, framesPerMultiframeMinusOne} + 6'h01;
    // step is one here, so range alone decides
    kValid_nxt = modeValid_nxt && (kLen_nxt >= K_MIN) && (kLen_nxt <= K_MAX)
      && (((kLen_nxt - K_MIN) % K_STEP) == 6'h00);
    did_nxt = deviceId;
    scr_nxt = scramblerEnable;
  end

  genvar gl;
  generate
    for (gl = 0; gl < LANES_TOTAL; gl++) begin : g_lane
      localparam logic [3:0] POS = 4'(gl % LANES_PER_LINK_MAX);
      localparam logic [1:0] LNK = 2'(gl / LANES_PER_LINK_MAX);
      assign laneEn_nxt[gl] = (POS < lanes_nxt) && (LNK < links_nxt);
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      modeValid_r <= 1'b0;
      kValid_r <= 1'b0;
      interleave_r <= 1'b0;
      decim_r <= 5'h00;
      links_r <= 2'h0;
      res_r <= 5'h00;
      ctrl_r <= 2'h0;
      nPrime_r <= 5'h00;
      octets_r <= 4'h0;
      samples_r <= 4'h0;
      lanes_r <= 4'h0;
      conv_r <= 4'h0;
      ratio_r <= 3'h0;
      pllMult_r <= 3'h0;
      pllBypass_r <= 1'b0;
      km1_r <= '0;
      kLen_r <= 6'h00;
      did_r <= '0;
      scr_r <= 1'b0;
      laneEn_r <= '0;
    end else begin
      modeValid_r <= modeValid_nxt;
      kValid_r <= kValid_nxt;
      interleave_r <= interleave_nxt;
      decim_r <= decim_nxt;
      links_r <= links_nxt;
      res_r <= res_nxt;
      ctrl_r <= ctrl_nxt;
      nPrime_r <= nPrime_nxt;
      octets_r <= octets_nxt;
      samples_r <= samples_nxt;
      lanes_r <= lanes_nxt;
      conv_r <= conv_nxt;
      ratio_r <= ratio_nxt;
      pllMult_r <= pllMult_nxt;
      pllBypass_r <= pllBypass_nxt;
      km1_r <= km1_nxt;
      kLen_r <= kLen_nxt;
      did_r <= did_nxt;
      scr_r <= scr_nxt;
      laneEn_r <= laneEn_nxt;
    end
  end

  assign modeValid = modeValid_r;
  assign kValid = kValid_r;
  assign interleaveEnable = interleave_r;
  assign decimationFactor = decim_r;
  assign linkCount = links_r;
  assign sampleResolution = res_r;
  assign controlBitsPerSample = ctrl_r;
  assign bitsPerSample = nPrime_r;
  assign lanesPerLink = lanes_r;
  assign convertersPerLink = conv_r;
  assign octetsPerFrame = octets_r;
  assign samplesPerFrame = samples_r;
  assign bitsPerClock = ratio_r;
  assign pllMultiplier = pllMult_r;
  assign pllBypass = pllBypass_r;
  assign multiframeLength = kLen_r;
  assign scramblerActive = scr_r;
  assign laneEnable = laneEn_r;

  // ==========================================================
  // alignment-sequence walker
  state_type state_r, state_nxt;
  logic [3:0] octIdx_r, octIdx_nxt;
  logic [2:0] lanePos_r, lanePos_nxt;
  logic linkSel_r, linkSel_nxt;
  logic fifoInReady, fifoOutValid, push, lastOctet, lastLane, lastLink;
  logic [7:0] octet;
  logic [STREAM_W-1:0] fifoOutData;

  assign lastOctet = (octIdx_r == OCT_CHKSUM);
  assign lastLane = ({1'b0, lanePos_r} == lanes_r - 4'h1);
  assign lastLink = ({1'b0, linkSel_r} == links_r - 2'h1);
  assign push = (state_r == EMIT) && linkEnable && fifoInReady;

  always_comb begin
    state_nxt = state_r;
    octIdx_nxt = octIdx_r;
    lanePos_nxt = lanePos_r;
    linkSel_nxt = linkSel_r;
    unique case (state_r)
      IDLE: begin
        octIdx_nxt = 4'h0;
        lanePos_nxt = 3'h0;
        linkSel_nxt = 1'b0;
        if (linkEnable && modeValid_r) begin
          state_nxt = EMIT;
        end
      end
      EMIT: begin
        if (!linkEnable) begin
          state_nxt = IDLE;
        end else if (push) begin
          octIdx_nxt = lastOctet ? 4'h0 : octIdx_r + 4'h1;
          if (lastOctet) begin
            lanePos_nxt = lastLane ? 3'h0 : lanePos_r + 3'h1;
            if (lastLane) begin
              linkSel_nxt = !linkSel_r;
              if (lastLink) begin
                state_nxt = HOLD;
              end
            end
          end
        end
      end
      HOLD: begin
        if (!linkEnable) begin
          state_nxt = IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= IDLE;
      octIdx_r <= 4'h0;
      lanePos_r <= 3'h0;
      linkSel_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      octIdx_r <= octIdx_nxt;
      lanePos_r <= lanePos_nxt;
      linkSel_r <= linkSel_nxt;
    end
  end

  ilas_octet_build u_build (
    .octetIdx(octIdx_r),
    .deviceId(did_r),
    .laneId({2'h0, lanePos_r}),
    .scrEnable(scr_r),
    .lanesM1({1'b0, lanes_r - 4'h1}),
    .octetsM1({4'h0, octets_r - 4'h1}),
    .kM1(km1_r),
    .convM1({4'h0, conv_r - 4'h1}),
    .resM1(res_r - 5'h01),
    .nPrimeM1(nPrime_r - 5'h01),
    .samplesM1({1'b0, samples_r - 4'h1}),
    .octet(octet)
  );

  // ==========================================================
  // buffered output stage; registered so that every output is a flop
  logic outValid_r, outValid_nxt, outLast_r, outLast_nxt, busy_r, busy_nxt;
  logic [7:0] outData_r, outData_nxt;
  logic [3:0] outLane_r, outLane_nxt;
  logic take;

  assign take = fifoOutValid && (!outValid_r || ilasReady);

  stream_fifo #(.WIDTH(STREAM_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .inValid(push),
    .inReady(fifoInReady),
    .inData({lastOctet && lastLane && lastLink, linkSel_r, lanePos_r, octet}),
    .outValid(fifoOutValid),
    .outReady(take),
    .outData(fifoOutData)
  );

  always_comb begin
    outValid_nxt = outValid_r;
    outData_nxt = outData_r;
    outLane_nxt = outLane_r;
    outLast_nxt = outLast_r;
    if (take) begin
      outValid_nxt = 1'b1;
      outData_nxt = fifoOutData[7:0];
      outLane_nxt = fifoOutData[11:8];
      outLast_nxt = fifoOutData[12];
    end else if (ilasReady) begin
      outValid_nxt = 1'b0;
    end
    busy_nxt = (state_nxt == EMIT) || fifoOutValid || outValid_nxt;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      outValid_r <= 1'b0;
      outData_r <= 8'h00;
      outLane_r <= 4'h0;
      outLast_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      outValid_r <= outValid_nxt;
      outData_r <= outData_nxt;
      outLane_r <= outLane_nxt;
      outLast_r <= outLast_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign ilasValid = outValid_r;
  assign ilasData = outData_r;
  assign ilasLane = outLane_r;
  assign ilasLast = outLast_r;
  assign ilasBusy = busy_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  mode_zero_a: assert property ($past(rst_b) && $past(linkModeCode) == MODE_SINGLE12_8L
    |-> lanesPerLink == 4'h4 && convertersPerLink == 4'h4 && bitsPerClock == 3'h4 && octetsPerFrame == 4'h8
    && samplesPerFrame == 4'h5)
    else $error("mode zero decode wrong");
  mode_one_a: assert property ($past(rst_b) && $past(linkModeCode) == MODE_SINGLE12_16L
    |-> lanesPerLink == 4'h8
    && convertersPerLink == 4'h8 && bitsPerClock == 3'h2 && sampleResolution == 5'h0C)
    else $error("mode one decode wrong");
  interleave_flag_a: assert property (modeValid |-> interleaveEnable && linkCount == 2'h2)
    else $error("interleave flag wrong");
  pll_select_a: assert property (pllBypass == (bitsPerClock == 3'h1)
    && (pllBypass || pllMultiplier == bitsPerClock))
    else $error("pll setting mismatch");
  // first edge after release still shows reset values, so the field is only compared from the second
  multiframe_len_a: assert property ($past(rst_b)
    |-> multiframeLength == {1'b0, $past(framesPerMultiframeMinusOne)} + 6'h01)
    else $error("multiframe length not field plus one");
  lane_power_a: assert property ($countones(laneEnable) == lanesPerLink * linkCount
    && (laneEnable[0] == modeValid))
    else $error("lane enable pattern wrong");
  zero_fields_a: assert property (push && (octIdx_r == OCT_ADJ_BID || octIdx_r == OCT_CS_N)
    |-> octet[7:5] == 3'h0)
    else $error("fixed zero field not zero");
  version_fields_a: assert property (push && octIdx_r == OCT_SUB_NP |-> octet[7:VER_LSB] == 3'h1)
    else $error("subclass version not one");
  ident_scr_a: assert property (push && octIdx_r == OCT_SCR_L |-> octet[SCR_BIT] == $past(scramblerEnable))
    else $error("scrambler bit not reported");
  lane_id_a: assert property (push && octIdx_r == OCT_LID |-> octet[4:0] == {2'h0, lanePos_r})
    else $error("lane id not lane position");
  hold_data_a: assert property (ilasValid && !ilasReady |=> ilasValid && $stable(ilasData)
    && $stable(ilasLane))
    else $error("stream word changed while stalled");
endmodule

// >>> ilas_sink.sv
// Purpose: receiver model that takes alignment-sequence words off the stream
// Assumes: stallPct lies between 0 and 100
// Notes: accepted words queue up for the bench to inspect
`timescale 1ns/1ps
module ilas_sink (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [6:0] stallPct,
  input wire logic ilasValid,
  input wire logic [7:0] ilasData,
  input wire logic [3:0] ilasLane,
  input wire logic ilasLast,
  output logic ilasReady
);
  // ==========================================================
  // accept and stall
  logic [12:0] rxQ[$];
  // m octet kept as packing info only, never taken as channel count
  always @(posedge clk_sys) begin
    if (rst_b && ilasValid && ilasReady) begin
      rxQ.push_back({ilasLast, ilasLane, ilasData});
    end
  end
  // random stalls stress the fifo full path
  always @(negedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ilasReady <= 1'b0;
    end else begin
      ilasReady <= ($urandom % 100) >= stallPct;
    end
  end
endmodule

// >>> jesd_mode_param_decode_test.sv
// Purpose: self-checking bench for the mode decoder and alignment stream
// Assumes: configuration moves only while linkEnable is low
// Notes: expected octets come from an integer model of the lane fields
`timescale 1ns/1ps
module jesd_mode_param_decode_test;
  import jesd_mode_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [MODE_W-1:0] linkModeCode = 5'h00;
  logic [KM1_W-1:0] framesPerMultiframeMinusOne = 5'h02;
  logic [DID_W-1:0] deviceId = 8'h00;
  logic scramblerEnable = 1'b0;
  logic linkEnable = 1'b0;
  logic [6:0] stallPct = 7'h00;
  logic ilasReady, modeValid, kValid, interleaveEnable, pllBypass, scramblerActive, ilasBusy, ilasValid, ilasLast;
  logic [4:0] decimationFactor, sampleResolution, bitsPerSample;
  logic [1:0] linkCount, controlBitsPerSample;
  logic [3:0] lanesPerLink, convertersPerLink, octetsPerFrame, samplesPerFrame, ilasLane;
  logic [2:0] bitsPerClock, pllMultiplier;
  logic [5:0] multiframeLength;
  logic [LANES_TOTAL-1:0] laneEnable;
  logic [7:0] ilasData;
  int fails = 0;
  int cmpCount = 0;
  int did, km1, scr;
  always #2.5 clk_sys = ~clk_sys;
  jesd_mode_param_decode dut_u (.clk_sys, .rst_b, .linkModeCode, .framesPerMultiframeMinusOne, .deviceId,
    .scramblerEnable, .linkEnable, .ilasReady, .modeValid, .kValid, .interleaveEnable, .decimationFactor,
    .linkCount, .sampleResolution, .controlBitsPerSample, .bitsPerSample, .lanesPerLink, .convertersPerLink,
    .octetsPerFrame, .samplesPerFrame, .bitsPerClock, .pllMultiplier, .pllBypass, .multiframeLength,
    .scramblerActive, .laneEnable, .ilasBusy, .ilasValid, .ilasData, .ilasLane, .ilasLast);
  ilas_sink sink_u (.clk_sys, .rst_b, .stallPct, .ilasValid, .ilasData, .ilasLane, .ilasLast, .ilasReady);
  // ==========================================================
  // compare and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    cmpCount++;
    if (seen !== expv) begin
      fails++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, expv);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // model of one lane's configuration octets
  function automatic logic [7:0] expOctet(int l, int lid, int idx);
    int f[13];
    // zero adjust, bank, cs, hd/cf and reserved revision fields one
    f = '{did, 0, lid, scr * 128 + l - 1, 7, km1, l - 1, 11, 43, 36, 0, 0, 0};
    if (idx == 13) begin
      return 8'((did + lid + scr + 2 * (l - 1) + km1 + 35) % 256);
    end
    return 8'(f[idx]);
  endfunction
  task automatic check_decode(input logic [4:0] code, input logic [4:0] km);
    int v;
    int l;
    linkModeCode = code;
    framesPerMultiframeMinusOne = km;
    scramblerEnable = 1'($urandom);
    repeat (2) @(negedge clk_sys);
    v = code < 2;
    l = code == 0 ? 4 : 8;
    check(modeValid, v);
    check(kValid, v && km >= 2);
    check(interleaveEnable, v);
    check({decimationFactor, linkCount}, v * 6);
    check({lanesPerLink, bitsPerClock}, v * (l * 8 + 16 / l));
    check(convertersPerLink, v * l);
    check(laneEnable, v ? (l == 4 ? 16'h0F0F : 16'hFFFF) : 16'h0000);
    if (v) begin
      check({pllMultiplier, pllBypass}, 32 / l);
      check({sampleResolution, bitsPerSample, controlBitsPerSample}, 32'h0000018C * 4);
      check({octetsPerFrame, samplesPerFrame}, 32'h00000085);
      check(multiframeLength, km + 1);
      check(scramblerActive, scramblerEnable);
    end
  endtask
  task automatic run_ilas(input logic [4:0] code, input logic [6:0] stall, input int abortAt);
    int l;
    int n;
    int k;
    logic [12:0] w;
    l = code == 0 ? 4 : 8;
    did = $urandom % 256;
    km1 = 2 + $urandom % 30;
    scr = $urandom % 2;
    linkModeCode = code;
    framesPerMultiframeMinusOne = 5'(km1);
    deviceId = 8'(did);
    scramblerEnable = 1'(scr);
    stallPct = stall;
    sink_u.rxQ.delete();
    repeat (3) @(negedge clk_sys);
    linkEnable = 1'b1;
    n = 0;
    while (sink_u.rxQ.size() < 28 * l && n < 4000 && !(abortAt > 0 && n == abortAt)) begin
      @(negedge clk_sys);
      n++;
    end
    linkEnable = 1'b0;
    n = 0;
    while (ilasBusy !== 1'b0 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    if (abortAt == 0) begin
      check(sink_u.rxQ.size(), 28 * l);
    end
    for (int i = 0; i < sink_u.rxQ.size(); i++) begin
      w = sink_u.rxQ[i];
      k = i / 14;
      check(w[7:0], expOctet(l, k % l, i % 14));
      check(w[12:8], {1'(i == 28 * l - 1), 1'(k / l), 3'(k % l)});
    end
    check(ilasBusy, 0);
    $display("test stream mode %0d stall %0d abort %0d done", code, stall, abortAt);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(21));
    repeat (20) @(negedge clk_sys);
    check({modeValid, ilasValid, ilasBusy, laneEnable}, 0);
    rst_b = 1'b1;
    for (int c = 0; c < 6; c++) begin
      check_decode(c < 4 ? 5'(c ^ 1) : 5'(2 + $urandom % 30), 5'($urandom));
    end
    check_decode(5'h00, 5'h01);
    check_decode(5'h01, 5'h1F);
    $display("test decode done");
    linkModeCode = 5'h05;
    repeat (2) @(negedge clk_sys);
    linkEnable = 1'b1;
    repeat (20) @(negedge clk_sys);
    check({ilasValid, ilasBusy}, 0);
    linkEnable = 1'b0;
    $display("test invalid mode done");
    run_ilas(5'h00, 7'h00, 0);
    run_ilas(5'h01, 7'h28, 0);
    run_ilas(5'h00, 7'h1E, 25);
    run_ilas(5'h01, 7'h00, 0);
    give_verdict();
  end
  initial begin
    #100000;
    fails++;
    give_verdict();
  end
endmodule
